// file: logic/lsc_pkg.sv
// constants and types for the led sink configuration register bank
// How it works
// - reg3 bit7 enables display string faults
// - bits 6:4 pick full scale current
// - grouping 000: four strings, 90 degrees
// - grouping 001: three strings, 120 degrees
// - grouping 010: two strings, 180 degrees
// - grouping 011: channel one sole display
// - grouping 100: two tied pairs, 180 degrees
// - grouping 101: all four tied, same phase
// - grouping 110: pair one-two, rest cluster
// - grouping 111: every channel is cluster
// - reg3 bit0 selects hybrid dimming
// - reg4 bit7 enables cluster faults
// - bits 6:5 set comparator gap
// - bits 4:3 set short threshold
// - bits 2:0 set headroom above saturation
package lsc_pkg;
  localparam logic [3:0] LSC_ADDR_GROUPING = 4'h0;
  localparam logic [3:0] LSC_ADDR_FAULT = 4'h1;
  localparam logic [3:0] LSC_ADDR_STATUS = 4'h2;
  localparam logic [7:0] LSC_GROUPING_RESET = 8'h00;
  localparam logic [7:0] LSC_FAULT_RESET = 8'h00;
  localparam int LSC_DISP_FAULT_BIT = 7;
  localparam int LSC_SCALE_LSB = 4;
  localparam int LSC_GROUP_LSB = 1;
  localparam int LSC_HYBRID_BIT = 0;
  localparam int LSC_CL_FAULT_BIT = 7;
  localparam int LSC_GAP_LSB = 5;
  localparam int LSC_THR_LSB = 3;
  localparam int LSC_HEAD_LSB = 0;
  typedef enum logic [2:0] {
    LSC_GRP_FOUR = 3'h0,
    LSC_GRP_THREE = 3'h1,
    LSC_GRP_TWO = 3'h2,
    LSC_GRP_ONE = 3'h3,
    LSC_GRP_PAIRS = 3'h4,
    LSC_GRP_ALL = 3'h5,
    LSC_GRP_ONE_TWO = 3'h6,
    LSC_GRP_CLUSTER = 3'h7
  } lsc_group_t;
endpackage

// file: logic/lsc_config.sv
// configuration register bank of a four channel led sink driver
`timescale 1ns/100ps
module lsc_config
  import lsc_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic [3:0] open_fault_i,
  input wire logic [3:0] short_fault_i,
  output logic [7:0] rdata_o,
  output logic [3:0] display_channel_o,
  output logic [3:0] cluster_channel_o,
  output logic [7:0] phase_step_o,
  output logic [3:0] fault_allow_o,
  output logic [3:0] fault_flag_o,
  output logic hybrid_dimming_o,
  output logic [7:0] full_scale_ma_o,
  output logic [9:0] comparator_gap_mv_o,
  output logic [6:0] short_threshold_dv_o,
  output logic [9:0] sink_headroom_mv_o
);
  logic [7:0] grouping_q;
  logic [7:0] fault_q;
  wire wr_group = write_i && (addr_i == LSC_ADDR_GROUPING);
  wire wr_fault = write_i && (addr_i == LSC_ADDR_FAULT);
  wire display_string_fault_enable = grouping_q[LSC_DISP_FAULT_BIT];
  wire [2:0] full_scale_current_select = grouping_q[LSC_SCALE_LSB +: 3];
  wire [2:0] string_grouping_select = grouping_q[LSC_GROUP_LSB +: 3];
  wire cluster_fault_enable = fault_q[LSC_CL_FAULT_BIT];
  wire [1:0] comparator_gap_select = fault_q[LSC_GAP_LSB +: 2];
  wire [1:0] short_threshold_select = fault_q[LSC_THR_LSB +: 2];
  wire [2:0] sink_headroom_select = fault_q[LSC_HEAD_LSB +: 3];
  logic [3:0] disp_d;
  logic [7:0] phase_d;
  logic [7:0] scale_d;
  logic [9:0] gap_d;
  logic [6:0] thr_d;
  logic [9:0] head_d;
  wire [3:0] allow_d = (disp_d & {4{display_string_fault_enable}})
    | (~disp_d & {4{cluster_fault_enable}});
  wire [3:0] flag_d = (fault_flag_o & ~({4{wr_fault}} & wdata_i[3:0]))
    | ((open_fault_i | short_fault_i) & allow_d);
  wire [7:0] rd_d = (addr_i == LSC_ADDR_GROUPING) ? grouping_q :
    (addr_i == LSC_ADDR_FAULT) ? fault_q :
    (addr_i == LSC_ADDR_STATUS) ? {4'h0, fault_flag_o} : 8'h00;

  always_comb begin
    case (lsc_group_t'(string_grouping_select))
      LSC_GRP_FOUR: begin disp_d = 4'hF; phase_d = 8'd90; end
      LSC_GRP_THREE: begin disp_d = 4'h7; phase_d = 8'd120; end
      LSC_GRP_TWO: begin disp_d = 4'h3; phase_d = 8'd180; end
      LSC_GRP_ONE: begin disp_d = 4'h1; phase_d = 8'd0; end
      LSC_GRP_PAIRS: begin disp_d = 4'hF; phase_d = 8'd180; end
      LSC_GRP_ALL: begin disp_d = 4'hF; phase_d = 8'd0; end
      LSC_GRP_ONE_TWO: begin disp_d = 4'h3; phase_d = 8'd0; end
      default: begin disp_d = 4'h0; phase_d = 8'd0; end
    endcase
  end

  always_comb begin
    case (full_scale_current_select)
      3'h0: scale_d = 8'd25;
      3'h1: scale_d = 8'd30;
      3'h2: scale_d = 8'd50;
      3'h3: scale_d = 8'd60;
      3'h4: scale_d = 8'd80;
      3'h5: scale_d = 8'd100;
      3'h6: scale_d = 8'd120;
      default: scale_d = 8'd150;
    endcase
    case (comparator_gap_select)
      2'h0: gap_d = 10'd1000;
      2'h1: gap_d = 10'd750;
      2'h2: gap_d = 10'd500;
      default: gap_d = 10'd250;
    endcase
    case (short_threshold_select)
      2'h2: thr_d = 7'd69;
      2'h3: thr_d = 7'd106;
      default: thr_d = 7'd36;
    endcase
    // printed table repeats code 011; 450 mV taken for it, 770 dropped
    case (sink_headroom_select)
      3'h7: head_d = 10'd50;
      3'h6: head_d = 10'd175;
      3'h5: head_d = 10'd300;
      3'h4: head_d = 10'd350;
      3'h3: head_d = 10'd450;
      3'h2: head_d = 10'd700;
      3'h1: head_d = 10'd875;
      default: head_d = 10'd1000;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      grouping_q <= LSC_GROUPING_RESET;
      fault_q <= LSC_FAULT_RESET;
      rdata_o <= 8'h00;
      display_channel_o <= 4'h0;
      cluster_channel_o <= 4'h0;
      phase_step_o <= 8'h00;
      fault_allow_o <= 4'h0;
      fault_flag_o <= 4'h0;
      hybrid_dimming_o <= 1'b0;
      full_scale_ma_o <= 8'h00;
      comparator_gap_mv_o <= 10'h000;
      short_threshold_dv_o <= 7'h00;
      sink_headroom_mv_o <= 10'h000;
    end else begin
      if (wr_group) grouping_q <= wdata_i;
      if (wr_fault) fault_q <= wdata_i;
      rdata_o <= read_i ? rd_d : 8'h00;
      display_channel_o <= disp_d;
      cluster_channel_o <= ~disp_d;
      phase_step_o <= phase_d;
      fault_allow_o <= allow_d;
      // set wins over a clear in the same cycle
      fault_flag_o <= flag_d;
      hybrid_dimming_o <= grouping_q[LSC_HYBRID_BIT];
      full_scale_ma_o <= scale_d;
      comparator_gap_mv_o <= gap_d;
      short_threshold_dv_o <= thr_d;
      sink_headroom_mv_o <= head_d;
    end
  end
endmodule // lsc_config

// file: tb/lsc_chk.sv
// concurrent checks for the led sink config bank
`timescale 1ns/100ps
module lsc_chk (
  input clock_i,
  input reset_i,
  input [3:0] addr_i,
  input [7:0] wdata_i,
  input write_i,
  input [3:0] display_channel_o,
  input hybrid_dimming_o,
  input [7:0] full_scale_ma_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // outputs follow a write two edges later
  wire wa = write_i && addr_i == 4'h0;
  wire h = wdata_i[0];
  wire y = hybrid_dimming_o;
  wire [2:0] s = wdata_i[6:4];
  wire [2:0] m = wdata_i[3:1];
  wire [3:0] dc = display_channel_o;
  wire [7:0] fs = full_scale_ma_o;
  chk_dim_mode: assert property (wa |-> ##2 y == $past(h, 2)) else $error("dim");
  chk_scale_low: assert property (wa && s == 0 |-> ##2 fs == 25) else $error("scale");
  chk_scale_top: assert property (wa && s == 7 |-> ##2 fs == 150) else $error("scale");
  chk_four_str: assert property (wa && m == 0 |-> ##2 dc == 15) else $error("four");
  chk_three_str: assert property (wa && m == 1 |-> ##2 dc == 7) else $error("three");
  chk_one_str: assert property (wa && m == 3 |-> ##2 dc == 1) else $error("one");
  chk_pair_str: assert property (wa && m == 6 |-> ##2 dc == 3) else $error("pair");
  chk_no_str: assert property (wa && m == 7 |-> ##2 dc == 0) else $error("cluster");
  cover property (wa && m == 5);
  cover property (wa && s == 7);
  cover property (wa && h);
endmodule // lsc_chk
bind lsc_config lsc_chk i_chk (.*);

// file: tb/testbench.sv
// random and corner tests for the led sink config bank
`timescale 1ns/100ps
module testbench;
  logic clock_i = 0, reset_i = 1, write_i = 0, read_i = 0, hybrid_dimming_o;
  logic [3:0] addr_i = 0, open_fault_i = 0, short_fault_i = 0, fault_flag_o;
  logic [3:0] display_channel_o, cluster_channel_o, fault_allow_o;
  logic [7:0] wdata_i = 0, rdata_o, r3, r4, phase_step_o, full_scale_ma_o;
  logic [9:0] comparator_gap_mv_o, sink_headroom_mv_o;
  logic [6:0] short_threshold_dv_o;
  logic [9:0] ds[8] = '{15,7,3,1,15,15,3,0}, ph[8] = '{90,120,180,0,180,0,0,0};
  logic [9:0] sc[8] = '{25,30,50,60,80,100,120,150}, hd[8] = '{1000,875,700,450,350,300,175,50};
  int seed = 32'h5F0F148D, err_total = 0, checked = 0, cyc = 0;
  lsc_config i_lsc_config (.*);
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) if (++cyc == 3000) begin
    err_total++;
    results();
  end
  task automatic chk(string n, logic [9:0] s, logic [9:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %0d seen %0d", n, e, s);
    end
  endtask
  // one bus cycle; a read compares against d
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
    @(posedge clock_i);
    write_i <= w;
    read_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    {write_i, read_i} <= 2'h0;
    #1 if (!w) chk("rdata", rdata_o, d);
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    reset_i <= 0;
    for (int i = 0; i < 16; i++) begin
      {r3, r4} = 16'($random(seed));
      r3[6:1] = {~i[2:0], i[2:0]};
      r4[6:0] = {i[1:0], i[3:2], i[2:0]};
      bus(1, 0, r3);
      bus(1, 1, r4);
      bus(0, 0, r3);
      bus(0, 1, r4);
      chk("scale", full_scale_ma_o, sc[r3[6:4]]);
      chk("hybrid", hybrid_dimming_o, r3[0]);
      chk("display", display_channel_o, ds[i[2:0]]);
      chk("cluster", cluster_channel_o, 4'(~ds[i[2:0]]));
      chk("phase", phase_step_o, ph[i[2:0]]);
      chk("allow", fault_allow_o, 4'(ds[i[2:0]] & {4{r3[7]}} | ~ds[i[2:0]] & {4{r4[7]}}));
      chk("gap", comparator_gap_mv_o, 1000 - 250 * r4[6:5]);
      chk("short", short_threshold_dv_o, r4[4] ? (r4[3] ? 106 : 69) : 36);
      chk("head", sink_headroom_mv_o, hd[r4[2:0]]);
      $display("test %0d done", i);
    end
    // sticky flags: display gate open, then a clear that meets a fresh fault
    bus(1, 0, 8'h80);
    bus(1, 1, 8'h00);
    @(posedge clock_i) open_fault_i <= 4'h5;
    @(posedge clock_i) open_fault_i <= 4'h0;
    bus(0, 2, 8'h05);
    @(posedge clock_i) short_fault_i <= 4'h1;
    bus(1, 1, 8'h05);
    @(posedge clock_i) short_fault_i <= 4'h0;
    bus(0, 2, 8'h01);
    // all cluster with the cluster gate shut: no flag may rise
    bus(1, 0, 8'h8E);
    bus(1, 1, 8'h0F);
    @(posedge clock_i) open_fault_i <= 4'hF;
    @(posedge clock_i) open_fault_i <= 4'h0;
    bus(0, 2, 8'h00);
    $display("flag test done");
    bus(0, 15, 0);
    results();
  end
  task automatic results();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
endmodule // testbench
